// ### irdec_fifo.sv
// Parameterised valid/ready FIFO used in the decoded bit path
`timescale 1ns/100ps
module irdec_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock_in,    // Clock
  input  wire logic             arst_n_in,   // Async reset, active low
  input  wire logic [WIDTH-1:0] wr_data_in,  // Write data
  input  wire logic             wr_valid_in, // Write request
  output logic                  wr_ready_out, // Room available
  output logic [WIDTH-1:0]      rd_data_out, // Read data
  output logic                  rd_valid_out, // Data available
  input  wire logic             rd_ready_in  // Reader takes the word
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
  logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
  logic [AW:0]      count_q, count_d;
  logic             do_wr, do_rd;

  // ==========================================================
  // Pointer and occupancy; full and empty come straight from the count
  always_comb begin
    wr_ready_out = (count_q < (AW+1)'(DEPTH));  // Full only at DEPTH words
    rd_valid_out = (count_q != '0);
    do_wr        = wr_valid_in && wr_ready_out;
    do_rd        = rd_valid_out && rd_ready_in;
    wr_ptr_d     = wr_ptr_q;
    rd_ptr_d     = rd_ptr_q;
    count_d      = count_q;
    if (do_wr) begin
      wr_ptr_d = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
    if (do_rd) begin
      rd_ptr_d = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
    if (do_wr && !do_rd) begin
      count_d = count_q + 1'b1;
    end else if (do_rd && !do_wr) begin
      count_d = count_q - 1'b1;
    end
  end

  // Storage has no reset; only words behind valid are ever read
  always_ff @(posedge clock_in) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
    end
  end

  assign rd_data_out = mem_q[rd_ptr_q];
endmodule // irdec_fifo

// ### irdec_partner.sv
// Far-side model: transceiver pin, baud strobe and UART bit consumer
`timescale 1ns/100ps
module irdec_partner (
  input  wire logic clock_in,      // Clock
  input  wire logic arst_n_in,     // Async reset, active low
  input  wire logic stall_in,      // Hold the consumer off
  output logic      baud_tick_out, // Baud strobe, 16 per bit
  output logic      ir_rx_out,     // Transceiver pin, pulse low
  output logic      ready_out      // Consumer ready
);
  logic [1:0] div_q;
  integer     seed;
  // ==========================================================
  // Pin idles high; set high at time 0 and held there until the first pulse
  initial begin
    seed = 32'hc6dc380d;
    ir_rx_out = 1'b1;
  end
  // Strobe every 4 clocks; ready is random so pops see stalls
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q <= 2'h0;
      baud_tick_out <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      baud_tick_out <= (div_q == 2'h3);
      ready_out <= !stall_in && (($random(seed) & 1) != 0);
    end
  end
  // ==========================================================
  // Falling edges spaced by gap strobes, each low for 3 strobes
  task automatic pulse(input int gap);
    repeat (gap - 3) @(posedge clock_in iff baud_tick_out);
    ir_rx_out <= 1'b0;
    repeat (3) @(posedge clock_in iff baud_tick_out);
    ir_rx_out <= 1'b1;
  endtask
endmodule // irdec_partner

// ### irdec_pkg.sv
// Package of constants and types for the infrared pulse decoder
package irdec_pkg;
  // ==========================================================
  // Counter layout, in baud clock periods (16 per bit period)
  localparam int unsigned CNT_W         = 5;
  localparam logic [4:0]  CNT_RESET_VAL = 5'h00; // Value after a falling edge
  localparam logic [4:0]  CNT_BIT_LEN   = 5'h10; // Baud clocks per bit period
  localparam logic [4:0]  CNT_WIN_OPEN  = 5'h0c; // Window opens 4 before expected pulse
  localparam logic [4:0]  CNT_WIN_CLOSE = 5'h08; // Window closes at count 8 of next period
  localparam int unsigned WIN_SPAN      = 24;    // Baud clocks from pulse to window close
  // ==========================================================
  // Buffer shape
  localparam int unsigned FIFO_WIDTH = 1;
  localparam int unsigned FIFO_DEPTH = 8;
  // ==========================================================
  // Decoder states
  typedef enum logic [1:0] {
    IRDEC_IDLE,
    IRDEC_FIRST,
    IRDEC_TRACK
  } irdec_state_t;
endpackage

// ### irdec_top.sv
// Receive-side infrared pulse decoder feeding a UART receiver
`timescale 1ns/100ps
module irdec_top
  import irdec_pkg::*;
(
  input  wire logic clock_in,                  // System clock, 25 MHz
  input  wire logic arst_n_in,                 // Async reset, active low
  input  wire logic baud_tick_in,              // One-cycle baud clock strobe (16x rate)
  input  wire logic infrared_codec_enable_in,  // Enable bit held in UART control reg
  input  wire logic ir_rx_in,                  // Transceiver receive pin, pulse low
  output logic      rx_bit_out,                // Decoded bit value
  output logic      rx_bit_valid_out,          // Decoded bit available
  input  wire logic rx_bit_ready_in,           // UART consumes the bit
  output logic      uart_rxd_out,              // Level-form serial data to UART
  output logic      overflow_out               // Bit lost, buffer was full
);
  // ==========================================================
  // Pin synchroniser: the first stage feeds only the second
  logic sync1_q, sync2_q, prev_q;
  logic sync1_d, sync2_d, prev_d;
  logic fall_edge;

  always_comb begin
    sync1_d   = ir_rx_in;
    sync2_d   = sync1_q;
    prev_d    = sync2_q;
    fall_edge = prev_q && !sync2_q;
  end

  // Idle line is high, so the chain resets high to avoid a fake edge
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  // ==========================================================
  // Window tracking state machine
  irdec_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic         hit_q, hit_d;      // Pulse seen in current window
  logic         bit_push;
  logic         bit_val;
  logic         in_window;

  // Window is the last 4 counts of one period plus the first 8 of the next
  always_comb begin
    in_window = (cnt_q >= CNT_WIN_OPEN) || (cnt_q < CNT_WIN_CLOSE);
  end

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    hit_d    = hit_q;
    bit_push = 1'b0;
    bit_val  = 1'b1;
    if (!infrared_codec_enable_in) begin
      state_d = IRDEC_IDLE;
      cnt_d   = CNT_RESET_VAL;
      hit_d   = 1'b0;
    end else begin
      if (baud_tick_in) begin
        cnt_d = (cnt_q == CNT_BIT_LEN - 5'h01) ? CNT_RESET_VAL : cnt_q + 5'h01;
      end
      unique case (state_q)
        IRDEC_IDLE: begin
          if (fall_edge) begin
            // Start bit pulse: first zero bit of the character
            state_d  = IRDEC_FIRST;
            cnt_d    = CNT_RESET_VAL;
            bit_push = 1'b1;
            bit_val  = 1'b0;
            hit_d    = 1'b0;
          end
        end
        IRDEC_FIRST, IRDEC_TRACK: begin
          // A pulse early in the window belongs to the coming bit
          if (fall_edge && in_window && !(state_q == IRDEC_FIRST && cnt_q < CNT_WIN_CLOSE)
              && !hit_q) begin
            cnt_d    = CNT_RESET_VAL;
            state_d  = IRDEC_TRACK;
            bit_push = 1'b1;
            bit_val  = 1'b0;
            hit_d    = 1'b1;
          end else if (fall_edge) begin
            cnt_d = CNT_RESET_VAL;
            // Out-of-window edge: the next window opens late again, not at once
            if (!hit_q) begin
              state_d = IRDEC_FIRST;
            end
          end else if (baud_tick_in && cnt_q == CNT_WIN_CLOSE - 5'h01
                       && state_q == IRDEC_TRACK && hit_q) begin
            // Count 8 after an accepted pulse closes its window; the next opens at count 12
            hit_d = 1'b0;
          end else if (baud_tick_in && cnt_q == CNT_WIN_CLOSE - 5'h01
                       && !hit_q && state_q == IRDEC_TRACK) begin
            bit_push = 1'b1;
            bit_val  = 1'b1;
            state_d  = IRDEC_IDLE;
          end else if (baud_tick_in && cnt_q == CNT_BIT_LEN - 5'h01
                       && state_q == IRDEC_FIRST) begin
            state_d = IRDEC_TRACK;     // Window for bit 1, open since count 12, stays open past the wrap
          end
        end
        default: begin
          state_d = IRDEC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= IRDEC_IDLE;
      cnt_q   <= CNT_RESET_VAL;
      hit_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      hit_q   <= hit_d;
    end
  end

  // ==========================================================
  // Baud ticks since the last detected edge; only the checks read it,
  // so it saturates rather than wrapping
  logic [CNT_W-1:0] span_q, span_d;

  always_comb begin
    span_d = span_q;
    if (fall_edge) begin
      span_d = CNT_RESET_VAL;
    end else if (baud_tick_in && span_q != '1) begin
      span_d = span_q + 5'h01;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      span_q <= CNT_RESET_VAL;
    end else begin
      span_q <= span_d;
    end
  end

  // ==========================================================
  // Bit buffer; the UART drains it at its own pace, so resync never
  // reaches into its timing
  logic fifo_ready;
  logic [0:0] fifo_dout;

  irdec_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in     (clock_in),
    .arst_n_in    (arst_n_in),
    .wr_data_in   (bit_val),
    .wr_valid_in  (bit_push),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (fifo_dout),
    .rd_valid_out (rx_bit_valid_out),
    .rd_ready_in  (rx_bit_ready_in)
  );

  // ==========================================================
  // Level output and sticky overflow; the UART itself realigns only on
  // the low start level, the decoder has no register set of its own
  logic uart_q, uart_d, ovf_q, ovf_d;

  always_comb begin
    uart_d = uart_q;
    ovf_d  = ovf_q;
    if (!infrared_codec_enable_in) begin
      uart_d = 1'b1;
      ovf_d  = 1'b0;
    end else if (bit_push) begin
      uart_d = bit_val;
      if (!fifo_ready) begin
        ovf_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uart_q <= 1'b1;
      ovf_q  <= 1'b0;
    end else begin
      uart_q <= uart_d;
      ovf_q  <= ovf_d;
    end
  end

  assign rx_bit_out   = fifo_dout[0];
  assign uart_rxd_out = uart_q;
  assign overflow_out = ovf_q;

  // ==========================================================
  // Checks
  chk_edge_resets_cnt: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (infrared_codec_enable_in && fall_edge && state_q != IRDEC_IDLE)
      |=> (cnt_q == CNT_RESET_VAL))
    else $error("counter not reset on falling edge");

  chk_start_gives_zero: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (infrared_codec_enable_in && state_q == IRDEC_IDLE && fall_edge)
      |=> (uart_q == 1'b0 && state_q == IRDEC_FIRST))
    else $error("start pulse not decoded as zero");

  chk_miss_gives_one: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (bit_push && bit_val && infrared_codec_enable_in)
      |=> (state_q == IRDEC_IDLE && uart_q == 1'b1))
    else $error("missed pulse not decoded as one");

  chk_window_span: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (bit_push && !bit_val && state_q != IRDEC_IDLE)
      |-> (span_q >= CNT_WIN_OPEN && span_q < CNT_W'(WIN_SPAN)))
    else $error("pulse accepted outside window");

  chk_span_close: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (bit_push && bit_val) |-> (span_q == CNT_W'(WIN_SPAN - 1) && baud_tick_in))
    else $error("window not closed 24 ticks after last edge");

  chk_close_at_eight: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (bit_push && bit_val) |-> (cnt_q == CNT_WIN_CLOSE - 5'h01 && baud_tick_in))
    else $error("window closed at wrong count");

  chk_hit_tracks: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (infrared_codec_enable_in && state_q != IRDEC_IDLE && bit_push && !bit_val)
      |=> (state_q == IRDEC_TRACK && hit_q))
    else $error("accepted pulse did not keep tracking");

  chk_disable_idle: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    !infrared_codec_enable_in |=> (state_q == IRDEC_IDLE && uart_q))
    else $error("decoder active while disabled");

  chk_fifo_order: assert property (
    @(posedge clock_in) disable iff (!arst_n_in)
    (rx_bit_valid_out && !rx_bit_ready_in) |=> $stable(rx_bit_out) && rx_bit_valid_out)
    else $error("held bit changed before taken");
endmodule // irdec_top

// ### tb.sv
// Self-checking bench for the infrared pulse decoder
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); miscompares++; end end
module tb;
  import irdec_pkg::*;
  logic clock_in;
  logic arst_n_in;
  logic infrared_codec_enable;
  logic stall;
  logic baud_tick, ir_rx, ready;
  logic rx_bit, rx_bit_valid, uart_rxd, overflow, mon_exp;
  logic exp_q[$];
  int   miscompares = 0;
  int   tests_run = 0;
  int   seed = 32'hc6dc380d;
  int   k;
  // ==========================================================
  always #20 clock_in = ~clock_in;
  irdec_top DUT (
    .clock_in                 (clock_in),
    .arst_n_in                (arst_n_in),
    .baud_tick_in             (baud_tick),
    .infrared_codec_enable_in (infrared_codec_enable),
    .ir_rx_in                 (ir_rx),
    .rx_bit_out               (rx_bit),
    .rx_bit_valid_out         (rx_bit_valid),
    .rx_bit_ready_in          (ready),
    .uart_rxd_out             (uart_rxd),
    .overflow_out             (overflow)
  );
  irdec_partner u_partner (
    .clock_in      (clock_in),
    .arst_n_in     (arst_n_in),
    .stall_in      (stall),
    .baud_tick_out (baud_tick),
    .ir_rx_out     (ir_rx),
    .ready_out     (ready)
  );
  // Watchdog: a stuck strobe or pin model must still end in the verdict
  initial begin
    repeat (90000) @(posedge clock_in);
    miscompares++;
    give_verdict();
  end
  // Each popped bit is matched with the oldest note; a bit with no note is a miss
  always @(posedge clock_in) begin
    if (arst_n_in && rx_bit_valid === 1'b1 && ready === 1'b1) begin
      mon_exp = exp_q.size() != 0 ? exp_q.pop_front() : 1'bx;
      `CHK("rx_bit", mon_exp, rx_bit)
    end
  end
  // ==========================================================
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clock_in iff baud_tick);
  endtask
  // Bounded wait until every note is used and the buffer is empty
  task automatic drain(input string nm);
    int n;
    stall <= 1'b0;
    for (n = 0; n < 3000 && (exp_q.size() != 0 || rx_bit_valid !== 1'b0); n++)
      @(posedge clock_in);
    if (n == 3000) begin
      miscompares++;
      give_verdict();
    end else begin
      `CHK("uart_rxd idle", 1'b1, uart_rxd)
      $display("test %s done", nm);
    end
  endtask
  // n pulses; gap fixed or random inside the window; frame ends in a 1
  task automatic frame(input int n, input int gap, input bit rnd);
    int i;
    for (i = 0; i < n; i++) exp_q.push_back(1'b0);
    exp_q.push_back(1'b1);
    for (i = 0; i < n; i++)
      u_partner.pulse(i == 0 ? 3 : (rnd ? 13 + {$random(seed)} % 10 : gap));
    ticks(30);
  endtask
  // ==========================================================
  initial begin
    clock_in = 1'b0;
    arst_n_in = 1'b0;
    infrared_codec_enable = 1'b0;
    stall = 1'b1;
    repeat (5) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(negedge clock_in);
    `CHK("uart_rxd reset", 1'b1, uart_rxd)
    `CHK("valid reset", 1'b0, rx_bit_valid)
    `CHK("overflow reset", 1'b0, overflow)
    @(posedge clock_in);
    infrared_codec_enable <= 1'b1;
    ticks(2);
    // Steady stream, level shows 0 inside the frame
    exp_q = '{1'b0, 1'b0, 1'b0, 1'b1};
    u_partner.pulse(3);
    ticks(2);
    `CHK("uart_rxd in frame", 1'b0, uart_rxd)
    u_partner.pulse(16);
    u_partner.pulse(16);
    ticks(30);
    drain("steady");
    frame(2, 13, 1'b0);
    drain("early edge");
    frame(2, 22, 1'b0);
    drain("late edge");
    // Pulse before the window only resyncs the count, after a start or a hit
    exp_q = '{1'b0, 1'b0, 1'b0, 1'b1};
    u_partner.pulse(3);
    u_partner.pulse(8);
    u_partner.pulse(16);
    u_partner.pulse(9);
    u_partner.pulse(16);
    ticks(30);
    drain("resync");
    // Pulse after window close: a 1, idle, then a fresh start
    exp_q = '{1'b0, 1'b1, 1'b0, 1'b1};
    u_partner.pulse(3);
    u_partner.pulse(28);
    ticks(30);
    drain("missed window");
    for (k = 0; k < 6; k++) frame(1 + {$random(seed)} % 4, 0, 1'b1);
    drain("random frames");
    // Disabled decoder ignores the pin
    infrared_codec_enable <= 1'b0;
    u_partner.pulse(3);
    u_partner.pulse(16);
    ticks(30);
    drain("disabled");
    // Fill the buffer with the consumer held off, then drain it
    infrared_codec_enable <= 1'b1;
    stall <= 1'b1;
    ticks(2);
    for (k = 0; k < 10; k++) u_partner.pulse(k == 0 ? 3 : 16);
    ticks(30);
    `CHK("overflow set", 1'b1, overflow)
    repeat (FIFO_DEPTH) exp_q.push_back(1'b0);
    drain("overflow");
    `CHK("overflow sticky", 1'b1, overflow)
    infrared_codec_enable <= 1'b0;
    repeat (2) @(posedge clock_in);
    `CHK("overflow cleared", 1'b0, overflow)
    give_verdict();
  end
endmodule // tb
